// [hdl/qpc_consts.svh]
// register offsets, field positions and reset values of the position counter
`ifndef QPC_CONSTS_SVH
`define QPC_CONSTS_SVH
`define QPC_OFS_CTRL      8'h00
`define QPC_OFS_FILT      8'h04
`define QPC_OFS_POS       8'h08
`define QPC_OFS_MAX       8'h0C
`define QPC_OFS_IRQ_STAT  8'h10
`define QPC_OFS_IRQ_CLR   8'h14
`define QPC_OFS_IRQ_EN    8'h18
`define QPC_BIT_ERR       15
`define QPC_BIT_INDEX     12
`define QPC_BIT_DIR       11
`define QPC_MODE_HI       10
`define QPC_MODE_LO       8
`define QPC_BIT_IDX_RST   2
`define QPC_BIT_IRQ_OFF   8
`define QPC_IRQ_ERR       0
`define QPC_IRQ_INDEX     1
`define QPC_IRQ_BITS      2
`define QPC_RST_REG       16'h0000
`define QPC_RST_MAX       16'hFFFF
`define QPC_ERR_DOWN      16'hFFFF
`endif

// [hdl/qpc_pkg.sv]
// types shared by the position counter design
package qpc_pkg;
  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_X2_INDEX = 3'b100,
    MODE_X2_MATCH = 3'b101,
    MODE_X4_INDEX = 3'b110,
    MODE_X4_MATCH = 3'b111
  } decoder_mode_t;
  typedef struct packed {
    logic index_input;
    logic phase_b_input;
    logic phase_a_input;
  } enc_sample_t;
endpackage : qpc_pkg

// [hdl/quadrature_position_counter.sv]
// quadrature encoder position counter with wishbone register slave
// What this block does
// - takes a first phase, a second phase and a once-per-turn index input.
// - keeps a 16-bit position count that moves by one on each count pulse, or wraps between the limit and zero in modes 101/111.
// - first phase leading the second is forward, lagging is reverse.
// - an internal direction signal alone decides up or down for each pulse.
// - a 3-bit mode field at bits 10:8 of the control register picks the mode.
// - count error checking runs only in the index-reset modes 110 and 100.
// - the checked count is compared with 0xFFFF down or limit plus one up.
// - a detected error sets the error flag at control bit 15 and asks an irq.
// - the error irq is held off while filter control bit 8 is set, flag still set.
// - after an error the count keeps running until it naturally wraps.
// - the natural wrap after an error raises no interrupt.
// - the error flag is read/write and stays set until software clears it.
// - modes 100/101 count on both edges of the first phase only.
// - modes 110/111 count on every single-phase edge of both phases; a change of both at once is not counted.
// - in index modes an index pulse clears the count only if index reset is on.
//
// Implementation choices: register access over Wishbone and the address map.
`include "qpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_counter
  import qpc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // encoder pins
  input  wire logic        phase_a_input,
  input  wire logic        phase_b_input,
  input  wire logic        index_input,
  // interrupt
  output logic             irq
);

  enc_sample_t        sync1;
  enc_sample_t        sync2;
  enc_sample_t        prev;
  logic               count_direction;
  logic [15:0]        position_count;
  logic [15:0]        max_count_limit;
  logic               count_error_flag;
  logic               count_error_irq_disable;
  logic               index_reset_enable;
  decoder_mode_t      decoder_mode_select;
  logic [`QPC_IRQ_BITS-1:0] irq_stat;
  logic [`QPC_IRQ_BITS-1:0] irq_en;

  // pin synchronisers; sync1 feeds only sync2
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= {index_input, phase_b_input, phase_a_input};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // edge and pulse decode
  logic a_chg;
  logic b_chg;
  logic both_chg;
  logic dir_now;
  logic cnt_pulse;
  logic idx_mode;
  logic max_mode;
  logic idx_edge;
  assign a_chg    = sync2.phase_a_input ^ prev.phase_a_input;
  assign b_chg    = sync2.phase_b_input ^ prev.phase_b_input;
  assign both_chg = a_chg & b_chg;
  // a leading b gives up on every single-phase edge
  assign dir_now  = sync2.phase_a_input ^ prev.phase_b_input;
  assign idx_mode = (decoder_mode_select == MODE_X2_INDEX) ||
                    (decoder_mode_select == MODE_X4_INDEX);
  assign max_mode = (decoder_mode_select == MODE_X2_MATCH) ||
                    (decoder_mode_select == MODE_X4_MATCH);
  always_comb begin
    case (decoder_mode_select)
      MODE_X2_INDEX, MODE_X2_MATCH: cnt_pulse = a_chg & ~b_chg;
      MODE_X4_INDEX, MODE_X4_MATCH: cnt_pulse = a_chg ^ b_chg;
      default:                      cnt_pulse = 1'b0;
    endcase
  end
  assign idx_edge = sync2.index_input & ~prev.index_input;

  // direction follows the last valid single-phase edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_direction <= 1'b0;
    end else if ((a_chg ^ b_chg)) begin
      count_direction <= dir_now;
    end
  end

  // next count value from the direction signal alone
  logic        cnt_up;
  logic [15:0] next_pos;
  logic        err_det;
  logic        idx_rst;
  assign cnt_up = (a_chg ^ b_chg) ? dir_now : count_direction;
  always_comb begin
    if (cnt_up) begin
      if (max_mode && position_count == max_count_limit) begin
        next_pos = 16'h0000;
      end else begin
        next_pos = position_count + 16'h0001;
      end
    end else begin
      if (max_mode && position_count == 16'h0000) begin
        next_pos = max_count_limit;
      end else begin
        next_pos = position_count - 16'h0001;
      end
    end
  end
  // error values checked only in index modes, wrap itself is silent
  assign err_det = idx_mode && cnt_pulse && !both_chg &&
                   (cnt_up ? (next_pos == max_count_limit + 16'h0001)
                           : (next_pos == `QPC_ERR_DOWN));
  assign idx_rst = idx_mode && index_reset_enable && idx_edge;

  // wishbone decode; writes act on the acking edge
  logic        wr;
  logic [15:0] wmask;
  logic [15:0] wdat;
  assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat  = wb_dat_i[15:0];
  logic wr_ctrl;
  logic wr_pos;
  assign wr_ctrl = wr && wb_adr_i == `QPC_OFS_CTRL;
  assign wr_pos  = wr && wb_adr_i == `QPC_OFS_POS;

  // position counter; software write beats hardware motion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      position_count <= `QPC_RST_REG;
    end else if (wr_pos) begin
      position_count <= (position_count & ~wmask) | (wdat & wmask);
    end else if (idx_rst) begin
      position_count <= 16'h0000;
    end else if (cnt_pulse) begin
      position_count <= next_pos;
    end
  end

  // control, filter and limit registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      decoder_mode_select     <= MODE_OFF;
      index_reset_enable      <= 1'b0;
      count_error_irq_disable <= 1'b0;
      max_count_limit         <= `QPC_RST_MAX;
    end else if (wr) begin
      if (wb_adr_i == `QPC_OFS_CTRL && wb_sel_i[1]) begin
        decoder_mode_select <= decoder_mode_t'(wdat[`QPC_MODE_HI:`QPC_MODE_LO]);
      end
      if (wb_adr_i == `QPC_OFS_CTRL && wb_sel_i[0]) begin
        index_reset_enable <= wdat[`QPC_BIT_IDX_RST];
      end
      if (wb_adr_i == `QPC_OFS_FILT && wb_sel_i[1]) begin
        count_error_irq_disable <= wdat[`QPC_BIT_IRQ_OFF];
      end
      if (wb_adr_i == `QPC_OFS_MAX) begin
        max_count_limit <= (max_count_limit & ~wmask) | (wdat & wmask);
      end
    end
  end

  // error flag: a detection in the clearing cycle still sets it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_error_flag <= 1'b0;
    end else if (err_det) begin
      count_error_flag <= 1'b1;
    end else if (wr_ctrl && wb_sel_i[1]) begin
      count_error_flag <= wdat[`QPC_BIT_ERR];
    end
  end

  // sticky irq status, write-one clear, set beats clear
  logic [`QPC_IRQ_BITS-1:0] irq_set;
  logic [`QPC_IRQ_BITS-1:0] irq_clr;
  assign irq_set[`QPC_IRQ_ERR]   = err_det && !count_error_irq_disable;
  assign irq_set[`QPC_IRQ_INDEX] = idx_mode && idx_edge;
  assign irq_clr = (wr && wb_adr_i == `QPC_OFS_IRQ_CLR && wb_sel_i[0]) ?
                   wdat[`QPC_IRQ_BITS-1:0] : '0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en <= '0;
    end else if (wr && wb_adr_i == `QPC_OFS_IRQ_EN && wb_sel_i[0]) begin
      irq_en <= wdat[`QPC_IRQ_BITS-1:0];
    end
  end
  // level output, registers feed it directly
  assign irq = |(irq_stat & irq_en);

  // read mux; unmapped offsets read zero and still ack
  logic [15:0] rdat;
  always_comb begin
    rdat = 16'h0000;
    case (wb_adr_i)
      `QPC_OFS_CTRL: begin
        rdat[`QPC_BIT_ERR]                 = count_error_flag;
        rdat[`QPC_BIT_INDEX]               = sync2.index_input;
        rdat[`QPC_BIT_DIR]                 = count_direction;
        rdat[`QPC_MODE_HI:`QPC_MODE_LO]    = decoder_mode_select;
        rdat[`QPC_BIT_IDX_RST]             = index_reset_enable;
      end
      `QPC_OFS_FILT:     rdat[`QPC_BIT_IRQ_OFF] = count_error_irq_disable;
      `QPC_OFS_POS:      rdat = position_count;
      `QPC_OFS_MAX:      rdat = max_count_limit;
      `QPC_OFS_IRQ_STAT: rdat[`QPC_IRQ_BITS-1:0] = irq_stat;
      `QPC_OFS_IRQ_EN:   rdat[`QPC_IRQ_BITS-1:0] = irq_en;
      default:           rdat = 16'h0000;
    endcase
  end

  // one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {16'h0000, rdat};
    end
  end

  // checks
  property p_ack_single;
    @(posedge clk) disable iff (sys_rst) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

  property p_forward;
    @(posedge clk) disable iff (sys_rst)
      (a_chg && !b_chg && sync2.phase_a_input && !sync2.phase_b_input) |=> count_direction;
  endproperty
  a_forward: assert property (p_forward) else $error("a leading b not forward");

  property p_step_one;
    @(posedge clk) disable iff (sys_rst)
      (cnt_pulse && !idx_rst && !wr_pos && idx_mode) |=>
        (position_count == $past(position_count) + 16'h0001) ||
        (position_count == $past(position_count) - 16'h0001);
  endproperty
  a_step_one: assert property (p_step_one) else $error("count did not move by one");

  property p_both_ignored;
    @(posedge clk) disable iff (sys_rst)
      (both_chg && !idx_rst && !wr_pos) |=> $stable(position_count);
  endproperty
  a_both_ignored: assert property (p_both_ignored) else $error("double change counted");

  property p_x2_b_ignored;
    @(posedge clk) disable iff (sys_rst)
      (!decoder_mode_select[1] && b_chg && !a_chg && !idx_rst && !wr_pos)
        |=> $stable(position_count);
  endproperty
  a_x2_b_ignored: assert property (p_x2_b_ignored) else $error("x2 counted phase b");

  property p_err_only_idx;
    @(posedge clk) disable iff (sys_rst)
      $rose(count_error_flag) |-> $past(idx_mode) || $past(wr_ctrl);
  endproperty
  a_err_only_idx: assert property (p_err_only_idx) else $error("error outside index mode");

  property p_err_sets;
    @(posedge clk) disable iff (sys_rst)
      err_det |=> count_error_flag ##1 (count_error_flag || $past(wr_ctrl));
  endproperty
  a_err_sets: assert property (p_err_sets) else $error("error flag not set");

  property p_err_irq_off;
    @(posedge clk) disable iff (sys_rst)
      (err_det && count_error_irq_disable && !irq_stat[`QPC_IRQ_ERR])
        |=> !irq_stat[`QPC_IRQ_ERR] && count_error_flag;
  endproperty
  a_err_irq_off: assert property (p_err_irq_off) else $error("disabled error irq raised");

  property p_flag_sticky;
    @(posedge clk) disable iff (sys_rst) (count_error_flag && !wr_ctrl) |=> count_error_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("error flag dropped");

  property p_idx_reset;
    @(posedge clk) disable iff (sys_rst) (idx_rst && !wr_pos) |=> position_count == 16'h0000;
  endproperty
  a_idx_reset: assert property (p_idx_reset) else $error("index did not clear");

  c_error: cover property (@(posedge clk) disable iff (sys_rst) $rose(count_error_flag));
  c_index: cover property (@(posedge clk) disable iff (sys_rst) idx_rst);
  c_irq:   cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));

endmodule : quadrature_position_counter
`default_nettype wire

// [verification/quad_encoder_model.sv]
// behavioural incremental encoder with two phases and an index
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // commands from the bench
  input  wire logic step,
  input  wire logic fwd,
  input  wire logic jump,
  input  wire logic idx_req,
  // encoder pins
  output logic      phase_a_input,
  output logic      phase_b_input,
  output logic      index_input
);
  logic [1:0] ph;
  // quarter-step state, gray order 00,10,11,01 going forward
  always_ff @(posedge clk) begin
    if (sys_rst) ph <= 2'b00;
    else if (jump) ph <= ph + 2'd2; // both phases flip: only when the bench asks
    else if (step) ph <= fwd ? ph + 2'd1 : ph - 2'd1;
  end
  // first phase leads going forward
  assign phase_a_input = ph[1] ^ ph[0];
  assign phase_b_input = ph[1];
  // index only while both phases are low
  assign index_input = idx_req && ph == 2'b00;
endmodule : quad_encoder_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the quadrature position counter
`include "qpc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import qpc_pkg::*;
  logic          clk, sys_rst, cyc, stb, we, ack, irq, pa, pb, ix, st, dr, jmp, ireq, eerr, lf;
  logic [7:0]    adr;
  logic [31:0]   wdat, rdat, rs;
  logic [15:0]   q, ep, emax;
  logic [1:0]    ph;
  logic [2:0]    mode;
  decoder_mode_t ml [4] = '{MODE_X2_MATCH, MODE_X4_MATCH, MODE_X2_INDEX, MODE_X4_INDEX};
  int            bad_count, checks_done;
  quadrature_position_counter i_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phase_a_input(pa), .phase_b_input(pb),
    .index_input(ix), .irq(irq));
  quad_encoder_model i_enc (.clk(clk), .sys_rst(sys_rst), .step(st), .fwd(dr), .jump(jmp),
    .idx_req(ireq), .phase_a_input(pa), .phase_b_input(pb), .index_input(ix));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // expected count after one quarter step from the bench's own phase copy
  function automatic logic [15:0] next_pos(input logic [15:0] p, input logic f);
    if (!mode[2] || (!mode[1] && ph[0] == f)) return p;
    if (mode[0] && f && p == emax) return 16'h0000;
    if (mode[0] && !f && p == 16'h0000) return emax;
    return f ? p + 16'h0001 : p - 16'h0001;
  endfunction : next_pos
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; a leading edge keeps strobe low a cycle between cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[15:0];
    {cyc, stb} <= 2'b00;
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 16'h0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask : wr
  // one quarter step; count lands three edges after the pin change
  task automatic step(input logic f);
    logic [15:0] n;
    n = next_pos(ep, f);
    if (mode[2] && !mode[0] && n !== ep && n === (f ? emax + 16'h0001 : 16'hFFFF)) eerr = 1'b1;
    {ep, lf} = {n, f};
    ph = f ? ph + 2'd1 : ph - 2'd1;
    {st, dr} <= {1'b1, f};
    @(posedge clk);
    st <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : step
  // main sequence
  initial begin
    {cyc, stb, we, st, dr, jmp, ireq, eerr, lf, adr, wdat, ep, q, ph, mode} = '0;
    {sys_rst, emax, rs, bad_count, checks_done} = {1'b1, 16'hFFFF, 32'h5782432D, 64'h0};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`QPC_OFS_MAX);
    chk("max reset", `QPC_RST_MAX, q);
    rd(`QPC_OFS_CTRL);
    chk("ctrl reset", `QPC_RST_REG, q);
    rd(8'h1C);
    chk("unmapped", 16'h0000, q);
    step(1'b1);
    rd(`QPC_OFS_POS);
    chk("pos idle", ep, q);
    emax = 16'h0007;
    wr(`QPC_OFS_MAX, emax);
    wr(`QPC_OFS_IRQ_EN, 16'h0003);
    // random walk around the small limit in every counting mode
    foreach (ml[i]) begin
      {mode, ep, eerr} = {ml[i], 16'h0005, 1'b0};
      wr(`QPC_OFS_POS, ep);
      wr(`QPC_OFS_CTRL, {5'h00, mode, 8'h00});
      repeat (40) begin
        rs = xs(rs);
        step(rs[0]);
        rd(`QPC_OFS_POS);
        chk("pos", ep, q);
      end
      rd(`QPC_OFS_CTRL);
      chk("err flag", {eerr, 15'h0000}, q & 16'h8000);
      if (mode[1]) chk("dir", {4'h0, lf, 11'h000}, q & 16'h0800);
      chk("irq", {15'h0000, eerr}, {15'h0000, irq});
      wr(`QPC_OFS_IRQ_CLR, 16'h0003);
    end
    // error with its irq held off, then raised, masked and cleared
    {mode, ep} = {3'b110, emax};
    wr(`QPC_OFS_CTRL, 16'h0600);
    wr(`QPC_OFS_FILT, 16'h0100);
    wr(`QPC_OFS_POS, emax);
    step(1'b1);
    rd(`QPC_OFS_CTRL);
    chk("flag held off", 16'h8000, q & 16'h8000);
    rd(`QPC_OFS_IRQ_STAT);
    chk("stat held off", 16'h0000, q & 16'h0001);
    wr(`QPC_OFS_FILT, 16'h0000);
    step(1'b0);
    step(1'b1);
    chk("irq on", 16'h0001, {15'h0000, irq});
    wr(`QPC_OFS_IRQ_EN, 16'h0000);
    rd(`QPC_OFS_IRQ_STAT);
    chk("stat kept", 16'h0001, q & 16'h0001);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(`QPC_OFS_IRQ_CLR, 16'h0001);
    rd(`QPC_OFS_IRQ_STAT);
    chk("stat cleared", 16'h0000, q & 16'h0001);
    // index pulse with the reset enable off, then on
    while (ph != 2'b00) step(1'b1);
    for (int en = 0; en < 2; en++) begin
      wr(`QPC_OFS_CTRL, {5'h00, mode, 5'h00, en[0], 2'b00});
      wr(`QPC_OFS_POS, 16'h0003);
      ep = en[0] ? 16'h0000 : 16'h0003;
      ireq <= 1'b1;
      repeat (4) @(posedge clk);
      // index still high here, so the synchronised pin must read back set
      rd(`QPC_OFS_CTRL);
      chk("index pin", 16'h1000, q & 16'h1000);
      ireq <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`QPC_OFS_POS);
      chk("index reset", ep, q);
      rd(`QPC_OFS_IRQ_STAT);
      chk("index stat", 16'h0002, q & 16'h0002);
      wr(`QPC_OFS_IRQ_CLR, 16'h0003);
    end
    // both phases flip in one sample: no count, later steps still count
    jmp <= 1'b1;
    @(posedge clk);
    jmp <= 1'b0;
    repeat (5) @(posedge clk);
    ph = ph + 2'd2;
    rd(`QPC_OFS_POS);
    chk("pos jump", ep, q);
    step(1'b1);
    rd(`QPC_OFS_POS);
    chk("pos after jump", ep, q);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
